/* logic/serial_core_pkg.sv */
package serial_core_pkg;
  // ****************************************
  // Operating modes
  // ****************************************
  typedef enum logic [1:0] {MODE_SPI, MODE_I2C, MODE_UART} serial_mode_e;
  // Character size and frame lengths
  localparam int CHAR_BITS = 8;
  localparam logic [4:0] SPI_LAST_EDGE = 5'h0f;
  localparam logic [3:0] UART_LAST_BIT = 4'h9;
  localparam logic [3:0] I2C_ACK_BIT = 4'h8;
  // Bit clock: main clock cycles per bit clock tick
  localparam int BIT_CLOCK_DIV = 4;
  // Stall is confirmed after this many bit clock ticks with the line low
  localparam logic [1:0] STALL_CONFIRM_TICKS = 2'h3;
  // Transmit queue depth
  localparam int TX_QUEUE_DEPTH = 8;
  // Idle level of a serial data output
  localparam logic LINE_IDLE = 1'b1;
endpackage

/* logic/char_fifo.sv */
`timescale 1ns/100ps
// ****************************************
// Small synchronous FIFO for transmit characters
// ****************************************
module char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_in_data,
  input wire logic i_in_valid,
  output logic o_in_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic o_out_valid,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];  // Storage
  logic [AW-1:0] wr_reg;  // Write pointer
  logic [AW-1:0] rd_reg;  // Read pointer
  logic [AW:0] cnt_reg;  // Fill level
  logic push;
  logic pop;
  assign o_in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data = mem_reg[rd_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  // Storage write
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= i_in_data;
    end
  end
  // Pointers and level; wrap by depth so odd depths also work
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* logic/serial_core.sv */
`timescale 1ns/100ps
// How it works
// - I2C byte on SCL fall sets written flag
// - Written flag still set: hold SCL low
// - Clock-low flag; stall confirmed after three ticks
// - SPI transfer-active flag drops after completion
// - Clock request follows transfer-active flag
// - Transmit flag while queue not full; receive flag on character
// - UART complete only when transmit buffer empty
// - SPI clock idles at polarity select level
// - Slave receives and sends first bit correctly
// - Slave-enable pin input or output by select in four-pin master mode
// - Inactive slave-enable aborts master transfer
module serial_core
  import serial_core_pkg::*;
#(
  parameter int DATA_WIDTH = CHAR_BITS,
  parameter int QUEUE_DEPTH = TX_QUEUE_DEPTH,
  parameter int BIT_DIV = BIT_CLOCK_DIV
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_spi_link_clk,
  input wire logic i_software_reset_bit,
  input wire logic [1:0] i_mode,
  input wire logic i_spi_master,
  input wire logic i_four_pin,
  input wire logic i_clock_phase_select,
  input wire logic i_clock_polarity_select,
  input wire logic i_slave_enable_mode_select,
  input wire logic [DATA_WIDTH-1:0] i_transmit_buffer,
  input wire logic i_tx_valid,
  output logic o_transmit_flag,
  input wire logic i_rx_read,
  output logic [DATA_WIDTH-1:0] o_receive_buffer,
  output logic o_receive_flag,
  input wire logic i_txc_clear,
  output logic o_transmit_complete_flag,
  output logic o_transfer_active_flag,
  output logic o_clock_request,
  output logic o_clock_line_low_flag,
  output logic o_stall_confirmed,
  output logic o_sclk,
  output logic o_sclk_oe,
  output logic o_sdo,
  input wire logic i_sdi,
  input wire logic i_slave_enable_pin,
  output logic o_slave_enable_pin,
  output logic o_slave_enable_oe,
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_uart_txd
);
  // ****************************************
  // Common control
  // ****************************************
  logic hold;  // Core held idle by reset or software reset
  logic is_spi;
  logic is_i2c;
  logic is_uart;
  logic tick;  // Bit clock tick
  logic [$clog2(BIT_DIV+1)-1:0] div_reg;  // Bit clock divider
  assign hold = i_rst || i_software_reset_bit;
  assign is_spi = (i_mode == MODE_SPI);
  assign is_i2c = (i_mode == MODE_I2C);
  assign is_uart = (i_mode == MODE_UART);
  assign tick = (div_reg == '0);
  // Bit clock divider; free running so stall timing has a base
  always_ff @(posedge i_sys_clk) begin
    if (hold) begin
      div_reg <= '0;
    end else begin
      div_reg <= tick ? ($clog2(BIT_DIV+1))'(BIT_DIV-1) : div_reg - 1'b1;
    end
  end
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] ste_sync_reg;
  logic [1:0] sdi_sync_reg;
  logic scl_prev_reg;  // Last synced SCL, for edges
  // Two flops per pin; only the second stage feeds logic
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      ste_sync_reg <= 2'h3;
      sdi_sync_reg <= 2'h0;
      scl_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], i_scl};
      sda_sync_reg <= {sda_sync_reg[0], i_sda};
      ste_sync_reg <= {ste_sync_reg[0], i_slave_enable_pin};
      sdi_sync_reg <= {sdi_sync_reg[0], i_sdi};
      scl_prev_reg <= scl_sync_reg[1];
    end
  end
  // ****************************************
  // Transmit queue
  // ****************************************
  logic [DATA_WIDTH-1:0] q_data;
  logic q_valid;
  logic q_take;  // Engine takes the head character
  char_fifo #(.WIDTH(DATA_WIDTH), .DEPTH(QUEUE_DEPTH)) u_tx_queue (
    .i_sys_clk(i_sys_clk),
    .i_rst(hold),
    .i_in_data(i_transmit_buffer),
    .i_in_valid(i_tx_valid),
    .o_in_ready(o_transmit_flag),
    .o_out_data(q_data),
    .o_out_valid(q_valid),
    .i_out_ready(q_take)
  );
  // ****************************************
  // SPI master
  // ****************************************
  typedef enum logic {M_IDLE, M_SHIFT} master_state_e;
  master_state_e m_state_reg;
  logic [4:0] edge_reg;  // Half-bit edge count
  logic [DATA_WIDTH-1:0] m_tx_reg;
  logic [DATA_WIDTH-1:0] m_rx_reg;
  logic sclk_reg;
  logic m_active;
  logic conflict_mode;  // Slave-enable pin used as conflict input
  logic ste_inactive;
  logic m_sample;
  logic m_done;
  assign m_active = (m_state_reg == M_SHIFT);
  assign conflict_mode = i_spi_master && i_four_pin && !i_slave_enable_mode_select;
  assign ste_inactive = conflict_mode && ste_sync_reg[1];  // Active low enable
  assign m_sample = edge_reg[0] == i_clock_phase_select;
  assign m_done = m_active && tick && (edge_reg == SPI_LAST_EDGE);
  // Master sequencer; an inactive enable aborts and blocks new transfers
  always_ff @(posedge i_sys_clk) begin
    if (hold || !is_spi || !i_spi_master) begin
      m_state_reg <= M_IDLE;
      edge_reg <= '0;
    end else if (ste_inactive) begin
      m_state_reg <= M_IDLE;
      edge_reg <= '0;
    end else if (m_state_reg == M_IDLE) begin
      if (q_valid && tick) begin
        m_state_reg <= M_SHIFT;
      end
    end else if (tick) begin
      edge_reg <= edge_reg + 1'b1;
      if (edge_reg == SPI_LAST_EDGE) begin
        m_state_reg <= M_IDLE;
        edge_reg <= '0;
      end
    end
  end
  // Clock level: toggles per edge, returns to polarity when idle
  always_ff @(posedge i_sys_clk) begin
    if (hold || !m_active) begin
      sclk_reg <= i_clock_polarity_select;
    end else if (tick) begin
      sclk_reg <= !sclk_reg;
    end
  end
  // Master shift registers
  always_ff @(posedge i_sys_clk) begin
    if (hold) begin
      m_tx_reg <= '0;
      m_rx_reg <= '0;
    end else if (!m_active) begin
      m_tx_reg <= q_data;
    end else if (tick) begin
      if (m_sample) begin
        m_rx_reg <= {m_rx_reg[DATA_WIDTH-2:0], sdi_sync_reg[1]};
      end else if (edge_reg != '0) begin
        m_tx_reg <= {m_tx_reg[DATA_WIDTH-2:0], 1'b0};
      end
    end
  end
  // ****************************************
  // SPI slave, link clock domain
  // ****************************************
  logic link_clk;  // Sample edge is the rising edge of this clock
  logic [2:0] l_cnt_reg;
  logic [DATA_WIDTH-1:0] l_shift_reg;
  logic [DATA_WIDTH-1:0] l_word_reg;  // Completed byte, stable after toggle
  logic l_toggle_reg;
  logic [DATA_WIDTH-1:0] s_tx_reg;  // Slave send byte, owned by main domain
  // Mode bits are static while running; they only pick the sample edge
  assign link_clk = i_spi_link_clk ^ (i_clock_polarity_select ^ i_clock_phase_select);
  // Slave shifter; the hold level clears it at once, so the first edge after release counts.
  // The master parks the clock at idle around release, so removal never meets an edge.
  always_ff @(posedge link_clk or posedge hold) begin
    if (hold) begin
      l_cnt_reg <= '0;
      l_shift_reg <= '0;
      l_word_reg <= '0;
      l_toggle_reg <= 1'b0;
    end else begin
      l_cnt_reg <= l_cnt_reg + 1'b1;
      l_shift_reg <= {l_shift_reg[DATA_WIDTH-2:0], i_sdi};
      if (l_cnt_reg == 3'h7) begin
        l_word_reg <= {l_shift_reg[DATA_WIDTH-2:0], i_sdi};
        l_toggle_reg <= !l_toggle_reg;
      end
    end
  end
  // ****************************************
  // Slave byte crossing into main domain
  // ****************************************
  logic [2:0] s_tog_sync_reg;
  logic s_byte;
  assign s_byte = s_tog_sync_reg[2] ^ s_tog_sync_reg[1];
  always_ff @(posedge i_sys_clk) begin
    if (hold) begin
      s_tog_sync_reg <= '0;
    end else begin
      s_tog_sync_reg <= {s_tog_sync_reg[1:0], l_toggle_reg};
    end
  end
  logic s_loaded_reg;  // A send byte is waiting in s_tx_reg
  // Next slave send byte is loaded when a byte finishes
  always_ff @(posedge i_sys_clk) begin
    if (hold) begin
      s_tx_reg <= '0;
    end else if (is_spi && !i_spi_master && q_valid && (s_byte || !s_loaded_reg)) begin
      s_tx_reg <= q_data;
    end
  end
  // Waiting flag for the slave send byte
  always_ff @(posedge i_sys_clk) begin
    if (hold) begin
      s_loaded_reg <= 1'b0;
    end else if (is_spi && !i_spi_master && q_valid) begin
      s_loaded_reg <= 1'b1;
    end
  end
  // ****************************************
  // I2C receiver with overflow stall
  // ****************************************
  logic [3:0] i_cnt_reg;
  logic [DATA_WIDTH-1:0] i_shift_reg;
  logic written_reg;  // Receive buffer written, not yet read
  logic stall_reg;  // SCL held low
  logic [1:0] low_cnt_reg;
  logic scl_rise;
  logic scl_fall;
  logic i_byte_fall;
  assign scl_rise = is_i2c && scl_sync_reg[1] && !scl_prev_reg;
  assign scl_fall = is_i2c && !scl_sync_reg[1] && scl_prev_reg;
  assign i_byte_fall = scl_fall && (i_cnt_reg == I2C_ACK_BIT) && !stall_reg;
  // Bit counter and data shifter; ack clock is counted, not stored
  always_ff @(posedge i_sys_clk) begin
    if (hold || !is_i2c) begin
      i_cnt_reg <= '0;
      i_shift_reg <= '0;
    end else if (scl_rise) begin
      if (i_cnt_reg == I2C_ACK_BIT + 4'h1) begin
        i_cnt_reg <= 4'h1;
      end else begin
        i_cnt_reg <= i_cnt_reg + 1'b1;
      end
      if (i_cnt_reg < I2C_ACK_BIT || i_cnt_reg > I2C_ACK_BIT) begin
        i_shift_reg <= {i_shift_reg[DATA_WIDTH-2:0], sda_sync_reg[1]};
      end
    end
  end
  // Written flag: set on byte fall; the set wins over a same-cycle read
  always_ff @(posedge i_sys_clk) begin
    if (hold || !is_i2c) begin
      written_reg <= 1'b0;
    end else if (i_byte_fall || (stall_reg && i_rx_read)) begin
      written_reg <= 1'b1;
    end else if (i_rx_read) begin
      written_reg <= 1'b0;
    end
  end
  // Stall when a byte lands on an unread buffer, until read
  always_ff @(posedge i_sys_clk) begin
    if (hold || !is_i2c) begin
      stall_reg <= 1'b0;
    end else if (i_byte_fall && written_reg && !i_rx_read) begin
      stall_reg <= 1'b1;
    end else if (i_rx_read) begin
      stall_reg <= 1'b0;
    end
  end
  // Count bit clock ticks with SCL low; saturates at the confirm count
  always_ff @(posedge i_sys_clk) begin
    if (hold || scl_sync_reg[1] || !is_i2c) begin
      low_cnt_reg <= '0;
    end else if (tick && low_cnt_reg != STALL_CONFIRM_TICKS) begin
      low_cnt_reg <= low_cnt_reg + 1'b1;
    end
  end
  assign o_clock_line_low_flag = is_i2c && !scl_sync_reg[1];
  assign o_stall_confirmed = (low_cnt_reg == STALL_CONFIRM_TICKS) && o_clock_line_low_flag;
  assign o_scl = 1'b0;
  assign o_scl_oe = stall_reg;
  // ****************************************
  // UART transmitter
  // ****************************************
  logic [3:0] u_cnt_reg;
  logic [DATA_WIDTH+1:0] u_frame_reg;  // Stop, data, start; LSB first
  logic u_busy_reg;
  logic u_last;
  assign u_last = u_busy_reg && tick && (u_cnt_reg == UART_LAST_BIT);
  always_ff @(posedge i_sys_clk) begin
    if (hold || !is_uart) begin
      u_busy_reg <= 1'b0;
      u_cnt_reg <= '0;
      u_frame_reg <= '1;
    end else if (!u_busy_reg) begin
      if (q_valid && tick) begin
        u_busy_reg <= 1'b1;
        u_frame_reg <= {1'b1, q_data, 1'b0};
      end
    end else if (tick) begin
      u_frame_reg <= {1'b1, u_frame_reg[DATA_WIDTH+1:1]};
      u_cnt_reg <= u_cnt_reg + 1'b1;
      if (u_last) begin
        u_busy_reg <= 1'b0;
        u_cnt_reg <= '0;
      end
    end
  end
  // Complete only when nothing waits; set wins over clear
  always_ff @(posedge i_sys_clk) begin
    if (hold) begin
      o_transmit_complete_flag <= 1'b0;
    end else if (u_last && !q_valid) begin
      o_transmit_complete_flag <= 1'b1;
    end else if (i_txc_clear) begin
      o_transmit_complete_flag <= 1'b0;
    end
  end
  // ****************************************
  // Shared receive buffer and queue pop
  // ****************************************
  logic rx_write;
  logic [DATA_WIDTH-1:0] rx_data;
  logic i_pending;  // Stalled I2C byte lands when the reader frees the buffer
  logic [DATA_WIDTH-1:0] m_rx_word;  // Master byte, last bit added when it lands on the last edge
  assign m_rx_word = m_sample ? {m_rx_reg[DATA_WIDTH-2:0], sdi_sync_reg[1]} : m_rx_reg;
  assign i_pending = stall_reg && i_rx_read;
  assign rx_write = m_done || (is_spi && !i_spi_master && s_byte) ||
                    (i_byte_fall && (!written_reg || i_rx_read)) || i_pending;
  assign rx_data = is_i2c ? i_shift_reg : (m_done ? m_rx_word : l_word_reg);
  assign q_take = (!m_active && is_spi && i_spi_master && !ste_inactive && tick) ||
                  (!u_busy_reg && is_uart && tick) ||
                  (is_spi && !i_spi_master && s_byte);
  // Buffer store
  always_ff @(posedge i_sys_clk) begin
    if (hold) begin
      o_receive_buffer <= '0;
    end else if (rx_write) begin
      o_receive_buffer <= rx_data;
    end
  end
  // Receive flag; a new character wins over a same-cycle read
  always_ff @(posedge i_sys_clk) begin
    if (hold) begin
      o_receive_flag <= 1'b0;
    end else if (rx_write) begin
      o_receive_flag <= 1'b1;
    end else if (i_rx_read) begin
      o_receive_flag <= 1'b0;
    end
  end
  // ****************************************
  // Busy, clock request and pins
  // ****************************************
  logic [1:0] s_mid_sync_reg;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_mid_sync_reg <= '0;
    end else begin
      s_mid_sync_reg <= {s_mid_sync_reg[0], (l_cnt_reg != '0)};
    end
  end
  assign o_transfer_active_flag = !i_software_reset_bit &&
    (m_active || u_busy_reg || (is_spi && !i_spi_master && s_mid_sync_reg[1]));
  assign o_clock_request = o_transfer_active_flag;
  assign o_sclk = sclk_reg;
  assign o_sclk_oe = is_spi && i_spi_master;
  assign o_sdo = is_spi ? (i_spi_master ? m_tx_reg[DATA_WIDTH-1] :
                 s_tx_reg[3'h7 - l_cnt_reg]) : LINE_IDLE;
  assign o_uart_txd = u_frame_reg[0];
  assign o_slave_enable_pin = !m_active;  // Active low enable
  assign o_slave_enable_oe = i_spi_master && i_four_pin && i_slave_enable_mode_select;
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence byte_on_full;
    i_byte_fall && written_reg && !i_rx_read;
  endsequence
  sequence master_finish;
    m_done ##1 !m_active;
  endsequence
  AST_STALL_HOLD: assert property (byte_on_full |=> o_scl_oe ##1 (o_scl_oe || $past(i_rx_read)))
    else $error("SCL not held on overflow");
  AST_WRITTEN_SET: assert property (i_byte_fall && !written_reg |=> written_reg)
    else $error("Written flag not set");
  AST_MASTER_IDLE: assert property (master_finish |-> !o_transfer_active_flag ||
    u_busy_reg || $past(q_valid))
    else $error("Busy stuck after transfer");
  AST_CLK_REQ: assert property (o_transfer_active_flag |-> o_clock_request)
    else $error("Clock request dropped while busy");
  AST_IDLE_LEVEL: assert property (!m_active ##1 !m_active |-> o_sclk ==
    $past(i_clock_polarity_select))
    else $error("SPI clock not at idle level");
  AST_RX_FLAG: assert property (rx_write && !hold |=> o_receive_flag)
    else $error("Receive flag missing");
  AST_TXC_EMPTY: assert property ($rose(o_transmit_complete_flag) |-> !$past(q_valid))
    else $error("Complete flag with data waiting");
  AST_ABORT: assert property (m_active && ste_inactive && !hold |=> !m_active)
    else $error("Transfer not aborted");
  AST_SWRST: assert property (i_software_reset_bit |=> !o_receive_flag && !m_active)
    else $error("Core not held in reset");
  AST_STALL_LOW: assert property (o_stall_confirmed |-> $past(o_clock_line_low_flag, 8))
    else $error("Stall confirmed with SCL high");
endmodule

/* bench/spi_master_peer.sv */
`timescale 1ns/100ps
// ****************************************
// External SPI master that drives the core while it is a slave
// ****************************************
module spi_master_peer (
  input wire logic i_cpol,
  input wire logic i_cpha,
  output logic o_link_clk,
  output logic o_mosi,
  input wire logic i_miso
);
  // Link clock stands still between frames
  initial begin
    o_link_clk = 1'b0;
    o_mosi = 1'b1;
  end
  // Park the clock at its idle level before the slave leaves reset
  task automatic park();
    o_link_clk = i_cpol;
  endtask
  // One byte MSB first; miso is taken just before the sample edge, while the slave still shows it
  task automatic xfer(input logic [7:0] d, output logic [7:0] got);
    for (int i = 7; i >= 0; i--) begin
      if (i_cpha) begin
        o_link_clk = ~o_link_clk;
        o_mosi = d[i];
        #16;
        got[i] = i_miso;
        o_link_clk = ~o_link_clk;
        #16;
      end else begin
        o_mosi = d[i];
        #16;
        got[i] = i_miso;
        o_link_clk = ~o_link_clk;
        #16;
        o_link_clk = ~o_link_clk;
      end
    end
    // Released data line shows the inverse, never a stale bit
    o_mosi = ~d[0];
  endtask
endmodule

/* bench/tb_top.sv */
`timescale 1ns/100ps
// ****************************************
// Self-checking bench for the serial core
// ****************************************
module tb_top;
  import serial_core_pkg::*;
  logic i_sys_clk, i_rst, swr, master, four_pin, cpha, cpol, stem, tx_valid, rx_read, txc_clr;
  logic [1:0] mode;
  logic [7:0] tx_data, rx_buf, got;
  logic tx_flag, rx_flag, txc, busy, clk_req, scl_low, stall, sclk, sclk_oe, sdo;
  logic ste_drv, ste_out, ste_oe, scl_drv, scl_out, scl_oe, sda, txd, link_clk, mosi;
  int err_total, n_checks, cyc, acc;
  // Loopback in master mode, peer data in slave mode
  wire sdi = master ? sdo : mosi;
  wire ste_wire = ste_oe ? ste_out : ste_drv;
  // Open-drain clock line with pull-up
  wire scl_wire = scl_drv & ~(scl_oe & ~scl_out);
  serial_core i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_spi_link_clk(link_clk),
    .i_software_reset_bit(swr), .i_mode(mode), .i_spi_master(master), .i_four_pin(four_pin),
    .i_clock_phase_select(cpha), .i_clock_polarity_select(cpol),
    .i_slave_enable_mode_select(stem), .i_transmit_buffer(tx_data), .i_tx_valid(tx_valid),
    .o_transmit_flag(tx_flag), .i_rx_read(rx_read), .o_receive_buffer(rx_buf),
    .o_receive_flag(rx_flag), .i_txc_clear(txc_clr), .o_transmit_complete_flag(txc),
    .o_transfer_active_flag(busy), .o_clock_request(clk_req), .o_clock_line_low_flag(scl_low),
    .o_stall_confirmed(stall), .o_sclk(sclk), .o_sclk_oe(sclk_oe), .o_sdo(sdo), .i_sdi(sdi),
    .i_slave_enable_pin(ste_wire), .o_slave_enable_pin(ste_out), .o_slave_enable_oe(ste_oe),
    .i_scl(scl_wire), .o_scl(scl_out), .o_scl_oe(scl_oe), .i_sda(sda), .o_uart_txd(txd));
  spi_master_peer i_peer (.i_cpol(cpol), .i_cpha(cpha), .o_link_clk(link_clk), .o_mosi(mosi),
    .i_miso(sdo));
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  // Holds valid across several pushes; counts what the queue accepted
  task automatic fill(input int n, input logic [7:0] base);
    acc = 0;
    tx_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      tx_data = base + 8'(i);
      if (tx_flag === 1'b1) acc++;
      tick(1);
    end
    tx_valid = 1'b0;
  endtask
  task automatic wait_rx(input int lim);
    for (int i = 0; i < lim && rx_flag !== 1'b1; i++) tick(1);
  endtask
  task automatic read_rx();
    rx_read = 1'b1;
    tick(1);
    rx_read = 1'b0;
  endtask
  // Software reset pulse between mode changes keeps mode bits static while running
  task automatic restart(input logic [1:0] m);
    swr = 1'b1;
    mode = m;
    tick(3);
    swr = 1'b0;
    tick(3);
  endtask
  task automatic t_reset();
    chk("tx_flag", tx_flag, 1);
    chk("rx_flag", rx_flag, 0);
    chk("busy", busy, 0);
    chk("clk_req", clk_req, 0);
    chk("sclk idle", sclk, cpol);
    chk("txd", txd, 1);
    chk("scl_oe", scl_oe, 0);
    $display("test reset done");
  endtask
  task automatic t_master();
    for (int m = 0; m < 4; m++) begin
      {cpol, cpha} = 2'(m);
      restart(2'h0);
      fill(1, 8'h5a ^ 8'(m));
      tick(20);
      chk("busy mid", busy, 1);
      chk("clk_req mid", clk_req, 1);
      chk("ste out", {ste_oe, ste_out}, 2'b10);
      chk("sclk_oe", sclk_oe, 1);
      wait_rx(200);
      chk("master rx", rx_buf, 8'h5a ^ 8'(m));
      read_rx();
      tick(30);
      chk("busy end", busy, 0);
      chk("clk_req end", clk_req, 0);
      chk("sclk idle", sclk, cpol);
    end
    fill(1, 8'h00);
    tick(100);
    chk("busy dummy", busy, 0);
    fill(1, 8'h11);
    tick(20);
    swr = 1'b1;
    tick(3);
    chk("busy swr", busy, 0);
    chk("rx_flag swr", rx_flag, 0);
    swr = 1'b0;
    $display("test master done");
  endtask
  task automatic t_conflict();
    stem = 1'b0;
    ste_drv = 1'b1;
    restart(2'h0);
    chk("ste_oe", ste_oe, 0);
    fill(9, 8'h20);
    chk("accepted", 8'(acc), 8'd8);
    chk("tx_flag full", tx_flag, 0);
    ste_drv = 1'b0;
    wait_rx(200);
    chk("first", rx_buf, 8'h20);
    read_rx();
    tick(20);
    ste_drv = 1'b1;
    tick(8);
    chk("busy abort", busy, 0);
    tick(80);
    chk("rx aborted", rx_flag, 0);
    ste_drv = 1'b0;
    // Six queued bytes take about 410 cycles; busy dips between bytes, so wait a fixed time
    tick(600);
    chk("drained", rx_buf, 8'h27);
    chk("busy drained", busy, 0);
    read_rx();
    fill(1, 8'h21);
    wait_rx(200);
    chk("rewrite", rx_buf, 8'h21);
    read_rx();
    stem = 1'b1;
    $display("test conflict done");
  endtask
  task automatic t_uart();
    int n;
    restart(2'h2);
    fill(3, 8'h41);
    for (n = 0; n < 300 && txc !== 1'b1; n++) tick(1);
    chk("late complete", 8'(n > 110), 1);
    chk("complete", txc, 1);
    chk("txd idle", txd, 1);
    txc_clr = 1'b1;
    tick(1);
    txc_clr = 1'b0;
    chk("complete clr", txc, 0);
    $display("test uart done");
  endtask
  task automatic t_slave();
    master = 1'b0;
    for (int p = 0; p < 2; p++) begin
      {cpol, cpha} = {1'(p), 1'b1};
      i_peer.park();
      restart(2'h0);
      fill(1, 8'h3c);
      tick(10);
      i_peer.xfer(8'ha5, got);
      wait_rx(20);
      if (rx_flag !== 1'b1) restart(2'h0);
      chk("slave rx", rx_buf, 8'ha5);
      chk("slave tx", got, 8'h3c);
      read_rx();
    end
    $display("test slave done");
  endtask
  task automatic i2c_byte(input logic [7:0] d);
    for (int b = 8; b >= 0; b--) begin
      sda = (b == 0) ? 1'b0 : d[b-1];
      tick(5);
      scl_drv = 1'b1;
      tick(5);
      scl_drv = 1'b0;
    end
  endtask
  task automatic t_i2c();
    restart(2'h1);
    // Clock line low before the first data bit, as after a start condition
    scl_drv = 1'b0;
    i2c_byte(8'h96);
    tick(10);
    chk("i2c first", rx_buf, 8'h96);
    i2c_byte(8'hc3);
    tick(30);
    chk("stall", scl_oe, 1);
    chk("line low", scl_low, 1);
    chk("confirmed", stall, 1);
    chk("held", rx_buf, 8'h96);
    read_rx();
    tick(5);
    chk("released", scl_oe, 0);
    chk("pending", rx_buf, 8'hc3);
    read_rx();
    tick(1);
    read_rx();
    chk("cleared", rx_flag, 0);
    $display("test i2c done");
  endtask
  initial begin
    {swr, cpha, cpol, tx_valid, rx_read, txc_clr, sda, ste_drv} = '0;
    {master, four_pin, stem, scl_drv} = 4'hf;
    mode = 2'h0;
    tx_data = 8'h00;
    i_rst = 1'b1;
    tick(5);
    i_rst = 1'b0;
    tick(1);
    t_reset();
    t_master();
    t_conflict();
    t_uart();
    t_slave();
    t_i2c();
    report_and_stop();
  end
endmodule
